// ==== core/aatx_pkg.sv ====
package aatx_pkg;

  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int unsigned TS_W = 32;
  localparam int unsigned PTR_W = 10;
  localparam int unsigned CID_W = 8;
  localparam int unsigned UUI_W = 5;
  localparam int unsigned SEQB_W = 3;
  localparam int unsigned LEN_W = 6;
  localparam logic [SEQB_W-1:0] SEQB_MAX = 3'h4;
  localparam logic [2:0] BUF_512B = 3'h0;
  localparam logic [2:0] BUF_1024B = 3'h1;
  localparam logic [PTR_W-1:0] MASK_512B = 10'h1ff;
  localparam logic [PTR_W-1:0] MASK_1024B = 10'h3ff;
  localparam logic [7:0] CPS_HDR_BYTES = 8'h04;
  localparam logic [4:0] VC_ALIGN_BITS = 5'h06;

  // Compression type selects which fixed UUI bits are used
  typedef enum logic [2:0] {
    AATX_C64 = 3'b000,
    AATX_C40 = 3'b001,
    AATX_C32 = 3'b010,
    AATX_C24 = 3'b011,
    AATX_C16 = 3'b100,
    AATX_SID = 3'b101
  } aatx_comp_t;

  // Packet request from voice/HDLC or CPU path
  typedef struct packed {
    logic cpu_inj;
    logic [CID_W-1:0] cpu_cid;
    aatx_comp_t comp;
    logic [LEN_W-1:0] length;
  } aatx_req_t;

  // Emitted CPS-packet header plus routing
  typedef struct packed {
    logic [CID_W-1:0] cid;
    logic [LEN_W-1:0] length;
    logic [UUI_W-1:0] uui;
    logic [31:0] vc_base;
  } aatx_pkt_t;

endpackage

// ==== core/aatx_seqgen.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// UUI sequence number from bus timestamp
// ----------------------------------------------------------------
module aatx_seqgen (
  input wire logic [aatx_pkg::TS_W-1:0] timestamp_i,
  input wire logic [aatx_pkg::TS_W-1:0] interval_i,
  input wire logic [aatx_pkg::TS_W-1:0] remainder_i,
  input wire logic [aatx_pkg::SEQB_W-1:0] seq_bits_i,
  output logic [3:0] seq_o
);
  logic [aatx_pkg::TS_W:0] adj;
  logic [aatx_pkg::TS_W-1:0] quot;
  logic [3:0] mask;

  // Remainder carries the count lost at each wrap, so quotient stays continuous
  always_comb begin
    adj = {1'b0, timestamp_i} + {1'b0, remainder_i};
    quot = (interval_i == '0) ? '0 : aatx_pkg::TS_W'(adj / {1'b0, interval_i});
    mask = (seq_bits_i >= aatx_pkg::SEQB_MAX) ? 4'hf : 4'(((5'h01 << seq_bits_i) - 5'h01));
    seq_o = quot[3:0] & mask;
  end
endmodule // aatx_seqgen

// ==== core/aatx_counters.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Free-running packet and octet counters
// ----------------------------------------------------------------
module aatx_counters (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sent_i,
  input wire logic [aatx_pkg::LEN_W-1:0] len_i,
  output logic [31:0] pkt_cnt_o,
  output logic [31:0] oct_cnt_o
);
  // Counters wrap silently; software takes differences
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pkt_cnt_o <= '0;
      oct_cnt_o <= '0;
    end else if (ce_i && sent_i) begin
      pkt_cnt_o <= pkt_cnt_o + 32'h0000_0001;
      oct_cnt_o <= oct_cnt_o + {26'h000_0000, len_i} + {24'h00_0000, aatx_pkg::CPS_HDR_BYTES};
    end
  end
endmodule // aatx_counters

// ==== core/aatx_conn.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// AAL2 transmit connection assembly, one connection
// ----------------------------------------------------------------
module aatx_conn (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [aatx_pkg::TS_W-1:0] timestamp_i,
  input wire logic [aatx_pkg::PTR_W-1:0] wr_ptr_i,
  input wire logic svc_evt_i,
  input wire logic start_marker_i,
  input wire logic [aatx_pkg::PTR_W-1:0] svc_bytes_i,
  input wire logic req_valid_i,
  input wire aatx_pkg::aatx_req_t req_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic pkt_valid_o,
  output aatx_pkg::aatx_pkt_t pkt_o,
  output logic started_o
);
  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_VCB = 8'h04;
  localparam logic [7:0] A_INTV = 8'h08;
  localparam logic [7:0] A_REM = 8'h0c;
  localparam logic [7:0] A_WRAP = 8'h10;
  localparam logic [7:0] A_UUI = 8'h14;
  localparam logic [7:0] A_NEXT = 8'h18;
  localparam logic [7:0] A_PCNT = 8'h1c;
  localparam logic [7:0] A_OCNT = 8'h20;
  localparam logic [7:0] A_TS = 8'h24;
  localparam int unsigned NCOMP = 6;

  logic [aatx_pkg::CID_W-1:0] cid_r;
  logic [aatx_pkg::SEQB_W-1:0] seqb_r;
  logic [2:0] bufsz_r;
  logic valid_r;
  logic [31:0] vcb_r;
  logic [aatx_pkg::TS_W-1:0] intv_r, rem_r, wrap_r;
  logic [aatx_pkg::UUI_W-1:0] fixed_r [NCOMP];
  logic [aatx_pkg::PTR_W-1:0] next_r;
  logic [aatx_pkg::TS_W-1:0] ts_q;
  logic [31:0] pcnt, ocnt;
  logic [3:0] seq;
  logic send;
  logic [aatx_pkg::PTR_W-1:0] bmask;

  // Buffer wrap mask from the size code; reserved codes fall back to the small buffer
  function automatic logic [aatx_pkg::PTR_W-1:0] buf_mask(input logic [2:0] code);
    return (code == aatx_pkg::BUF_1024B) ? aatx_pkg::MASK_1024B : aatx_pkg::MASK_512B;
  endfunction

  assign bmask = buf_mask(bufsz_r);

  // ----------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cid_r <= '0;
      seqb_r <= '0;
      bufsz_r <= aatx_pkg::BUF_512B;
      valid_r <= 1'b0;
      vcb_r <= '0;
      intv_r <= '0;
      wrap_r <= '0;
      for (int i = 0; i < NCOMP; i++) fixed_r[i] <= '0;
    end else if (ce_i && wr_i) begin
      unique case (addr_i)
        A_CTRL: begin
          cid_r <= wdata_i[7:0];
          seqb_r <= (wdata_i[10:8] > aatx_pkg::SEQB_MAX) ? aatx_pkg::SEQB_MAX : wdata_i[10:8];
          bufsz_r <= wdata_i[14:12];
          valid_r <= wdata_i[16];
        end
        A_VCB: vcb_r <= {wdata_i[31:6], 6'h00};
        A_INTV: intv_r <= wdata_i;
        A_WRAP: wrap_r <= wdata_i;
        A_UUI: for (int i = 0; i < NCOMP; i++) fixed_r[i] <= wdata_i[i*5 +: 5];
        default: ;
      endcase
    end
  end

  // Timestamp pins arrive from TDM domain: two flops, then a word is only taken once it
  // has held for two samples, so a multi-bit change caught mid-flight never reaches the divider
  logic [aatx_pkg::TS_W-1:0] ts_m;
  logic [aatx_pkg::TS_W-1:0] ts_s;
  logic [aatx_pkg::TS_W-1:0] ts_p;
  logic ts_take;
  assign ts_take = (ts_s == ts_p);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ts_m <= '0;
      ts_s <= '0;
      ts_p <= '0;
      ts_q <= '0;
    end else if (ce_i) begin
      ts_m <= timestamp_i;
      ts_s <= ts_m;
      ts_p <= ts_s;
      if (ts_take) ts_q <= ts_s;
    end
  end

  // Remainder gains wrap-increment when the accepted timestamp goes backwards
  always_ff @(posedge clk_i) begin
    if (reset_i) rem_r <= '0;
    else if (ce_i) begin
      if (wr_i && addr_i == A_REM) rem_r <= wdata_i;
      else if (ts_take && (ts_s < ts_q)) rem_r <= rem_r + wrap_r;
    end
  end

  // ----------------------------------------------------------------
  // xxPCM start-up and next-byte tracking
  // ----------------------------------------------------------------
  // First start-marked event only arms; later events send
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      started_o <= 1'b0;
      next_r <= '0;
    end else if (ce_i) begin
      if (svc_evt_i && valid_r && !started_o && start_marker_i) begin
        started_o <= 1'b1;
        next_r <= (next_r + wr_ptr_i) & bmask;
      end else if (send && !req_i.cpu_inj && svc_evt_i) begin
        next_r <= (next_r + svc_bytes_i) & bmask;
      end else if (wr_i && addr_i == A_NEXT) begin
        next_r <= wdata_i[aatx_pkg::PTR_W-1:0];
        started_o <= wdata_i[31];
      end
    end
  end

  // CPU packets bypass the start gate; voice needs valid and started
  assign send = req_valid_i && (req_i.cpu_inj || (svc_evt_i && valid_r && started_o));

  aatx_seqgen u_seq (
    .timestamp_i(ts_q),
    .interval_i(intv_r),
    .remainder_i(rem_r),
    .seq_bits_i(seqb_r),
    .seq_o(seq)
  );

  // ----------------------------------------------------------------
  // Packet header generation
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pkt_valid_o <= 1'b0;
      pkt_o <= '0;
    end else if (ce_i) begin
      pkt_valid_o <= send;
      if (send) begin
        pkt_o.cid <= req_i.cpu_inj ? req_i.cpu_cid : cid_r;
        pkt_o.length <= req_i.length;
        pkt_o.uui <= (fixed_r[req_i.comp] & ~{1'b0, 4'hf >> (4'h4 - 4'(seqb_r))})
                     | {1'b0, seq};
        pkt_o.vc_base <= vcb_r;
      end
    end
  end

  aatx_counters u_cnt (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .sent_i(send),
    .len_i(req_i.length),
    .pkt_cnt_o(pcnt),
    .oct_cnt_o(ocnt)
  );

  // ----------------------------------------------------------------
  // Read port, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) rdata_o <= '0;
    else if (ce_i && rd_i) begin
      unique case (addr_i)
        A_CTRL: rdata_o <= {15'h0000, valid_r, 1'b0, bufsz_r, 1'b0, seqb_r, cid_r};
        A_VCB: rdata_o <= vcb_r;
        A_INTV: rdata_o <= intv_r;
        A_REM: rdata_o <= rem_r;
        A_WRAP: rdata_o <= wrap_r;
        A_UUI: rdata_o <= {2'h0, fixed_r[5], fixed_r[4], fixed_r[3], fixed_r[2], fixed_r[1], fixed_r[0]};
        A_NEXT: rdata_o <= {started_o, 21'h00_0000, next_r};
        A_PCNT: rdata_o <= pcnt;
        A_OCNT: rdata_o <= ocnt;
        A_TS: rdata_o <= ts_q;
        default: rdata_o <= '0;
      endcase
    end
  end
endmodule // aatx_conn

// ==== sim/aatx_conn_sva.sv ====
`timescale 1ns/1ps
// ----
// Header and gating checks at the connection ports
// ----
module aatx_conn_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic svc_evt_i,
  input wire logic start_marker_i,
  input wire logic req_valid_i,
  input wire aatx_pkg::aatx_req_t req_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic pkt_valid_o,
  input wire aatx_pkg::aatx_pkt_t pkt_o,
  input wire logic started_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_cpu_cid;
    ce_i && req_valid_i && req_i.cpu_inj |=> pkt_valid_o && pkt_o.cid == $past(req_i.cpu_cid);
  endproperty
  a_cpu_cid: assert property (p_cpu_cid) else $error("cpu packet cid wrong");
  property p_len;
    ce_i && req_valid_i |=> !pkt_valid_o || pkt_o.length == $past(req_i.length);
  endproperty
  a_len: assert property (p_len) else $error("packet length wrong");
  property p_only_req;
    !(ce_i && req_valid_i) |=> !pkt_valid_o;
  endproperty
  a_only_req: assert property (p_only_req) else $error("packet without request");
  property p_need_svc;
    ce_i && req_valid_i && !req_i.cpu_inj && !svc_evt_i |=> !pkt_valid_o;
  endproperty
  a_need_svc: assert property (p_need_svc) else $error("voice packet without service event");
  property p_need_start;
    ce_i && req_valid_i && !req_i.cpu_inj && !started_o |=> !pkt_valid_o;
  endproperty
  a_need_start: assert property (p_need_start) else $error("voice packet before start");
  property p_first_quiet;
    ce_i && svc_evt_i && start_marker_i && !started_o |=> !pkt_valid_o;
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("packet on start event");
  property p_start_cause;
    !started_o && !(ce_i && (svc_evt_i && start_marker_i || wr_i && addr_i == 8'h18)) |=> !started_o;
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start flag set without cause");
  property p_vc_align;
    pkt_valid_o |-> pkt_o.vc_base[5:0] == 6'h00;
  endproperty
  a_vc_align: assert property (p_vc_align) else $error("vc base not aligned");
  property p_hold;
    !pkt_valid_o && !$past(reset_i) |-> $stable(pkt_o);
  endproperty
  a_hold: assert property (p_hold) else $error("packet header moved");
endmodule // aatx_conn_sva
bind aatx_conn aatx_conn_sva aatx_conn_sva_inst (.clk_i, .reset_i, .ce_i, .svc_evt_i, .start_marker_i,
  .req_valid_i, .req_i, .addr_i, .wr_i, .pkt_valid_o, .pkt_o, .started_o);

// ==== sim/aatx_cps_rx.sv ====
`timescale 1ns/1ps
// ----
// CPS receiver: own tally so device counters are judged by arrivals
// ----
module aatx_cps_rx (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pkt_valid_i,
  input wire aatx_pkg::aatx_pkt_t pkt_i,
  output logic [31:0] count_o,
  output logic [31:0] octets_o
);
  // Count each arriving packet and its bytes with header
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_o <= '0;
      octets_o <= '0;
    end else if (pkt_valid_i) begin
      count_o <= count_o + 32'h0000_0001;
      octets_o <= octets_o + 32'(pkt_i.length) + 32'h0000_0004;
    end
  end
endmodule // aatx_cps_rx

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; $display("BAD %0t %h %h", $time, a, e); end end
module testbench;
  logic clk_i = 0, reset_i = 1, svc = 0, stm = 0, rv = 0, wr = 0, rd = 0, pv, st, ce = 1;
  logic [31:0] ts = 0, wd = 0, rdata, rc, oc, iv, rm = 0;
  logic [9:0] wp = 0;
  logic [7:0] ad = 0;
  logic [15:0] r = 16'h4057;
  logic [29:0] fx;
  aatx_pkg::aatx_req_t rq = '0;
  aatx_pkg::aatx_pkt_t pk, ep;
  int fail_count = 0, checks_done = 0, cyc = 0;
  aatx_conn aatx_conn_inst (.clk_i, .reset_i, .ce_i(ce), .timestamp_i(ts), .wr_ptr_i(wp), .svc_evt_i(svc),
    .start_marker_i(stm), .svc_bytes_i(10'h008), .req_valid_i(rv), .req_i(rq), .addr_i(ad), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pkt_valid_o(pv), .pkt_o(pk), .started_o(st));
  aatx_cps_rx aatx_cps_rx_inst (.clk_i, .reset_i, .pkt_valid_i(pv), .pkt_i(pk), .count_o(rc), .octets_o(oc));
  // ----
  // Clock, hang guard and helpers
  // ----
  always #12.5 clk_i = ~clk_i;
  // A hang counts as a failure rather than running forever
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      conclude();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Fixed high bits kept, low bits replaced by the sequence count
  function automatic logic [4:0] euui(input logic [4:0] f, input logic [31:0] t, q, i, input int b);
    logic [31:0] m;
    m = (32'h1 << b) - 32'h1;
    return (f & ~m[4:0]) | 5'(((t + q) / i) & m);
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    ad <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk_i);
    wr <= 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    ad <= a;
    rd <= 1;
    @(posedge clk_i);
    rd <= 0;
    @(negedge clk_i);
    `CHK(rdata, e)
  endtask
  task automatic send(input logic c, s, m, input aatx_pkg::aatx_comp_t k, input logic [5:0] n);
    @(posedge clk_i);
    rq <= {c, 8'hc3, k, n};
    rv <= 1;
    svc <= s;
    stm <= m;
    @(posedge clk_i);
    rv <= 0;
    svc <= 0;
    stm <= 0;
    @(negedge clk_i);
  endtask
  task automatic voice(input int k, input logic [5:0] n, input int b);
    send(0, 1, 0, aatx_pkg::aatx_comp_t'(k), n);
    ep = {8'h5a, n, euui(fx[5*k+:5], ts, rm, iv, b), 32'h1234_5640};
    `CHK(pv, 1'b1)
    `CHK(pk, ep)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 0;
    rchk(8'h1c, 32'h0);
    rchk(8'h3c, 32'h0);
    `CHK(st, 1'b0)
    fx = {r[13:0], lfsr(r)};
    wreg(8'h04, 32'h1234_567f);
    wreg(8'h14, {2'b00, fx});
    wreg(8'h18, 32'h0);
    wreg(8'h00, 32'h0001_005a);
    send(0, 1, 0, aatx_pkg::AATX_C64, 6'h08);
    `CHK(pv, 1'b0)
    @(posedge clk_i);
    wp <= 10'h023;
    send(0, 1, 1, aatx_pkg::AATX_C64, 6'h08);
    `CHK(pv, 1'b0)
    `CHK(st, 1'b1)
    rchk(8'h18, 32'h8000_0023);
    // Every compression type against every sequence width
    for (int k = 0; k < 6; k++) begin
      for (int b = 0; b < 5; b++) begin
        r = lfsr(r);
        iv = {26'h0, r[5:0]} + 32'h1;
        wreg(8'h00, 32'h0001_005a | (b << 8));
        wreg(8'h08, iv);
        ts <= {r, lfsr(r)};
        repeat (3) @(posedge clk_i);
        voice(k, r[11:6], b);
      end
    end
    send(1, 0, 0, aatx_pkg::AATX_SID, 6'h3f);
    `CHK(pk.cid, 8'hc3)
    send(0, 0, 0, aatx_pkg::AATX_C64, 6'h05);
    `CHK(pv, 1'b0)
    wreg(8'h00, 32'h0000_045a);
    send(0, 1, 0, aatx_pkg::AATX_C64, 6'h05);
    `CHK(pv, 1'b0)
    // Timestamp wrap with interval 40 and four sequence bits
    wreg(8'h00, 32'h0001_045a);
    wreg(8'h08, 32'h0000_0028);
    iv = 32'h0000_0028;
    ts <= 32'hffff_fff0;
    repeat (3) @(posedge clk_i);
    wreg(8'h10, 32'h0000_0100);
    ts <= 32'h0000_0010;
    repeat (3) @(posedge clk_i);
    rm = 32'h0000_0100;
    voice(0, 6'h0a, 4);
    // Large buffer: next-byte must wrap at 1024, not 512
    wreg(8'h00, 32'h0001_145a);
    wreg(8'h18, 32'h8000_01fc);
    send(0, 1, 0, aatx_pkg::AATX_C64, 6'h08);
    rchk(8'h18, 32'h8000_0204);
    // Clock enable low freezes the block: no packet and no count
    @(posedge clk_i);
    ce <= 0;
    send(1, 0, 0, aatx_pkg::AATX_SID, 6'h01);
    `CHK(pv, 1'b0)
    @(posedge clk_i);
    ce <= 1;
    rchk(8'h1c, rc);
    rchk(8'h20, oc);
    conclude();
  end
endmodule // testbench
